// ---- logic/dpp_pkg.sv ----
`default_nettype none
package dpp_pkg;
    // ========================================================================
    // Geometry
    localparam int UNITS         = 2;
    localparam int PORTS_PER     = 3;
    localparam int PORT_W        = 8;
    localparam int LINES         = UNITS * PORTS_PER * PORT_W;
    localparam int UNIT_W        = PORTS_PER * PORT_W;

    // ========================================================================
    // Register map (byte addresses, one word each)
    localparam logic [7:0] OFF_CTRL0  = 8'h00;
    localparam logic [7:0] OFF_CTRL1  = 8'h04;
    localparam logic [7:0] OFF_PORT0  = 8'h10;
    localparam logic [7:0] OFF_PORT5  = 8'h24;
    localparam logic [7:0] OFF_ALLLO  = 8'h30;
    localparam logic [7:0] OFF_ALLHI  = 8'h34;
    localparam int         ADDR_W     = 8;

    // ========================================================================
    // Control word fields
    localparam int         CW_MODE_SET = 7;
    localparam int         CW_A_IN     = 4;
    localparam int         CW_CH_IN    = 3;
    localparam int         CW_B_IN     = 1;
    localparam int         CW_CL_IN    = 0;
    localparam logic [7:0] CW_RESET    = 8'h9B;
    localparam logic [7:0] CW_FIXED_MASK = 8'h64;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic a_in;
        logic b_in;
        logic ch_in;
        logic cl_in;
    } dpp_dir_t;

    typedef struct packed {
        logic [PORT_W-1:0] c;
        logic [PORT_W-1:0] b;
        logic [PORT_W-1:0] a;
    } dpp_ports_t;
endpackage : dpp_pkg
`default_nettype wire

// ---- logic/dpp_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module dpp_unit (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  cw_wr,
    input  wire logic [7:0]            cw_data,
    input  wire logic [2:0]            port_wr,
    input  wire dpp_pkg::dpp_ports_t   port_data,
    input  wire dpp_pkg::dpp_ports_t   pin_sync,
    output var  dpp_pkg::dpp_ports_t   pin_out,
    output var  dpp_pkg::dpp_ports_t   pin_oe,
    output var  dpp_pkg::dpp_ports_t   port_rd,
    output var  logic [7:0]            cw_rd
);
    // ========================================================================
    // Direction and output latches
    dpp_pkg::dpp_dir_t   dir_r;
    dpp_pkg::dpp_ports_t latch_r;
    dpp_pkg::dpp_ports_t oe_w;
    wire                 cw_ok;

    assign cw_ok = cw_wr && cw_data[dpp_pkg::CW_MODE_SET];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_r <= '{a_in: 1'b1, b_in: 1'b1, ch_in: 1'b1, cl_in: 1'b1};
        end else if (cw_ok) begin
            dir_r.a_in  <= cw_data[dpp_pkg::CW_A_IN];
            dir_r.ch_in <= cw_data[dpp_pkg::CW_CH_IN];
            dir_r.b_in  <= cw_data[dpp_pkg::CW_B_IN];
            dir_r.cl_in <= cw_data[dpp_pkg::CW_CL_IN];
        end
    end

    // Basic mode only: a control write with bit 7 set clears latches, as the classic part
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_r <= '0;
        end else if (cw_ok) begin
            latch_r <= '0;
        end else begin
            if (port_wr[0]) latch_r.a <= port_data.a;
            if (port_wr[1]) latch_r.b <= port_data.b;
            if (port_wr[2]) latch_r.c <= port_data.c;
        end
    end

    assign oe_w = {{4{~dir_r.ch_in}}, {4{~dir_r.cl_in}},
                   {8{~dir_r.b_in}}, {8{~dir_r.a_in}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= '0;
            pin_oe  <= '0;
            port_rd <= '0;
        end else begin
            pin_out <= latch_r;
            pin_oe  <= oe_w;
            // Output bits read back their latch, input bits the pin
            port_rd <= (latch_r & oe_w) | (pin_sync & ~oe_w);
        end
    end

    assign cw_rd = {1'b1, 2'b00, dir_r.a_in, dir_r.ch_in, 1'b0,
                    dir_r.b_in, dir_r.cl_in};
endmodule : dpp_unit
`default_nettype wire

// ---- logic/dpp_top.sv ----
// Contract
// - Two units, three 8-bit ports, 48 lines
// - Basic mode only: read pins, drive latches
// - Control word sets each group's direction
// - Bits 4,3,1,0 pick input per group
// - Everything input after reset, nothing driven
// - Input read: low gives 0, high 1
// - Output write: 0 drives low, 1 high
// - Lines ordered unit1 A,B,C then unit2
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dpp_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [47:0] io_line_in,
    output var  logic [47:0] io_line_out,
    output var  logic [47:0] io_line_oe
);
    localparam int NU = dpp_pkg::UNITS;
    localparam int UW = dpp_pkg::UNIT_W;

    // ========================================================================
    // Pin synchronisers
    logic [47:0] sync1_r;
    logic [47:0] sync2_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= io_line_in;
            sync2_r <= sync1_r;
        end
    end

    // ========================================================================
    // AXI4-Lite write path: address and data accepted in either order
    logic       aw_held_r;
    logic       w_held_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    wire        wr_go;
    wire        wr_hit;
    wire [7:0]  waddr_w;
    wire [31:0] wdata_w;
    wire [3:0]  wstrb_w;

    assign waddr_w = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wdata_w = w_held_r ? wdata_r : s_axi_wdata;
    assign wstrb_w = w_held_r ? wstrb_r : s_axi_wstrb;
    assign wr_go   = (aw_held_r || (s_axi_awvalid && s_axi_awready))
                  && (w_held_r || (s_axi_wvalid && s_axi_wready))
                  && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= dpp_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid
                          && !wr_go;
            s_axi_wready  <= !w_held_r && !s_axi_wready && !s_axi_bvalid
                          && !wr_go;
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r  <= s_axi_awaddr;
                aw_held_r <= !wr_go;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
                w_held_r <= !wr_go;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? dpp_pkg::RESP_OKAY
                                       : dpp_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Write decode
    wire [7:0] wword = {waddr_w[7:2], 2'b00};
    wire       wr_cw0 = wr_go && wword == dpp_pkg::OFF_CTRL0 && wstrb_w[0];
    wire       wr_cw1 = wr_go && wword == dpp_pkg::OFF_CTRL1 && wstrb_w[0];
    wire       wr_plo = wr_go && wword == dpp_pkg::OFF_ALLLO;
    wire       wr_phi = wr_go && wword == dpp_pkg::OFF_ALLHI;
    wire       in_port = wword >= dpp_pkg::OFF_PORT0
                      && wword <= dpp_pkg::OFF_PORT5;
    wire [7:0] pidx_w = (wword - dpp_pkg::OFF_PORT0) >> 2;
    assign wr_hit = wword == dpp_pkg::OFF_CTRL0 || wword == dpp_pkg::OFF_CTRL1
                 || in_port || wword == dpp_pkg::OFF_ALLLO
                 || wword == dpp_pkg::OFF_ALLHI;

    // Per logical port byte enables: single-port or 32/16-bit bulk words
    logic [5:0] pwr_w;
    always_comb begin
        pwr_w  = '0;
        for (int p = 0; p < 6; p++) begin
            if (wr_go && in_port && pidx_w == 8'(p) && wstrb_w[0])
                pwr_w[p] = 1'b1;
            if (wr_plo && p < 4 && wstrb_w[p])
                pwr_w[p] = 1'b1;
            if (wr_phi && p >= 4 && wstrb_w[p-4])
                pwr_w[p] = 1'b1;
        end
    end

    // ========================================================================
    // Units, logical port p = unit*3 + {A,B,C}
    wire [47:0] rd_lines_w;
    wire [47:0] out_all_w;
    wire [47:0] oe_all_w;
    wire [7:0]  cw_rd_w [NU];
    genvar u;
    generate
        for (u = 0; u < NU; u++) begin : g_unit
            dpp_pkg::dpp_ports_t out_w, oe_w, rd_w;
            dpp_unit u_unit (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .cw_wr     (u == 0 ? wr_cw0 : wr_cw1),
                .cw_data   (wdata_w[7:0]),
                .port_wr   (pwr_w[u*3 +: 3]),
                .port_data (pdata_sel(u, pwr_w, in_port, wr_phi,
                                      wdata_w)),
                .pin_sync  (sync2_r[u*UW +: UW]),
                .pin_out   (out_w),
                .pin_oe    (oe_w),
                .port_rd   (rd_w),
                .cw_rd     (cw_rd_w[u])
            );
            assign out_all_w[u*UW +: UW]  = out_w;
            assign oe_all_w[u*UW +: UW]   = oe_w;
            assign rd_lines_w[u*UW +: UW] = rd_w;
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_line_out <= '0;
            io_line_oe  <= '0;
        end else begin
            io_line_out <= out_all_w;
            io_line_oe  <= oe_all_w;
        end
    end

    // Bytes for a unit's three ports: selected lanes of the bulk or single-port word
    function automatic logic [23:0] pdata_sel(input int un,
                                              input logic [5:0] pw,
                                              input logic ip,
                                              input logic hi,
                                              input logic [31:0] d);
        logic [23:0] r;
        r = '0;
        if (ip)          r = {3{d[7:0]}};
        else if (hi)     r = {d[15:0], 8'h00};
        else if (un == 0) r = d[23:0];
        else             r = {d[15:0], d[31:24]};
        return r;
    endfunction : pdata_sel

    // ========================================================================
    // Read path: one outstanding read, answered a cycle after acceptance
    wire [7:0] rword = {s_axi_araddr[7:2], 2'b00};
    wire [7:0] ridx  = (rword - dpp_pkg::OFF_PORT0) >> 2;
    wire       r_port = rword >= dpp_pkg::OFF_PORT0
                     && rword <= dpp_pkg::OFF_PORT5;
    logic [31:0] rmux_w;
    logic        rhit_w;
    always_comb begin
        rmux_w = '0;
        rhit_w = 1'b1;
        if (rword == dpp_pkg::OFF_CTRL0)      rmux_w = {24'h0, cw_rd_w[0]};
        else if (rword == dpp_pkg::OFF_CTRL1) rmux_w = {24'h0, cw_rd_w[1]};
        else if (r_port)
            rmux_w = {24'h0, rd_lines_w[ridx[2:0]*8 +: 8]};
        else if (rword == dpp_pkg::OFF_ALLLO) rmux_w = rd_lines_w[31:0];
        else if (rword == dpp_pkg::OFF_ALLHI)
            rmux_w = {16'h0, rd_lines_w[47:32]};
        else rhit_w = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= dpp_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rmux_w;
                s_axi_rresp   <= rhit_w ? dpp_pkg::RESP_OKAY
                                        : dpp_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    wire unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot};
endmodule : dpp_top
`default_nettype wire

// ---- testbench/dpp_chk_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module dpp_chk (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [47:0] io_line_out,
    input wire logic [47:0] io_line_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire w_hs = s_axi_wvalid && s_axi_wready;
    function automatic logic grp_ok(logic [23:0] v);
        return v[7:0] == {8{v[0]}} && v[15:8] == {8{v[8]}}
            && v[19:16] == {4{v[16]}} && v[23:20] == {4{v[20]}};
    endfunction : grp_ok
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && w_hs;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ========================================================================
    // Properties
    chk_reset_quiet: assert property ($rose(aresetn) |->
        io_line_oe == 48'h0 && io_line_out == 48'h0)
        else $error("lines active after reset");
    chk_write_answer: assert property (s_wr_both |=> s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    chk_busy_ready: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("ready while busy");
    chk_group_dir: assert property (grp_ok(io_line_oe[23:0])
        && grp_ok(io_line_oe[47:24])) else $error("group split");
    // Any change on io_line_oe or io_line_out must trace back to a recent register write
    chk_oe_cause: assert property ($changed(io_line_oe) |->
        $past(w_hs) || $past(w_hs, 2) || $past(w_hs, 3))
        else $error("direction changed alone");
    chk_out_cause: assert property ($changed(io_line_out) |->
        $past(w_hs) || $past(w_hs, 2) || $past(w_hs, 3))
        else $error("output changed alone");
endmodule : dpp_chk
`default_nettype wire

// ---- testbench/dpp_ext_dev.sv ----
`timescale 1ns/10ps
`default_nettype none
module dpp_ext_dev (
    input  wire logic [47:0] ext_val,
    input  wire logic [47:0] ext_en,
    input  wire logic [47:0] io_line_out,
    input  wire logic [47:0] io_line_oe,
    output var  logic [47:0] io_line_in
);
    // Released lines float high through the pull-ups
    assign io_line_in = (io_line_oe & io_line_out)
        | (~io_line_oe & ((ext_en & ext_val) | ~ext_en));
endmodule : dpp_ext_dev
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, seed = 32'h945D65CC;
    logic [47:0] ext_val = 48'h0, ext_en = 48'h0;
    wire logic   awready, wready, bvalid, arready, rvalid;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [47:0] lin, lout, loe;
    logic [7:0]  cwm [2];
    logic [7:0]  lat [6];
    int          fails = 0, n_checks = 0, cyc = 0;
    always #2.5 aclk = ~aclk;
    dpp_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .io_line_in(lin), .io_line_out(lout), .io_line_oe(loe));
    dpp_ext_dev u_ext (.ext_val(ext_val), .ext_en(ext_en),
        .io_line_out(lout), .io_line_oe(loe), .io_line_in(lin));
    // ========================================================================
    // Reference model and helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [47:0] exp_oe();
        logic [47:0] v;
        v = 48'h0;
        for (int u = 0; u < 2; u++) begin
            v[u*24 +: 8]    = {8{~cwm[u][4]}};
            v[u*24+8 +: 8]  = {8{~cwm[u][1]}};
            v[u*24+16 +: 4] = {4{~cwm[u][0]}};
            v[u*24+20 +: 4] = {4{~cwm[u][3]}};
        end
        return v;
    endfunction : exp_oe
    function automatic logic [47:0] exp_lvl();
        logic [47:0] o, l;
        o = exp_oe();
        for (int p = 0; p < 6; p++) l[p*8 +: 8] = lat[p];
        return (o & l) | (~o & ((ext_en & ext_val) | ~ext_en));
    endfunction : exp_lvl
    task automatic chk(input string nm, input logic [47:0] ex, got);
        n_checks++;
        if (got !== ex) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    // ========================================================================
    // Bus master: ready for the answer is raised late to test holding
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        forever begin
            @(posedge aclk);
            if (bvalid && bready) break;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (!awvalid && !wvalid) bready <= 1'h1;
        end
        r = bresp;
        bready <= 1'h0;
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        forever begin
            @(posedge aclk);
            if (rvalid && rready) break;
            if (arvalid && arready) arvalid <= 1'h0;
            if (!arvalid) rready <= 1'h1;
        end
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : axr
    task automatic cw_wr(input int u, input logic [7:0] cw);
        logic [1:0] r;
        axw(dpp_pkg::OFF_CTRL0 + 8'(4*u), {24'h0, cw}, r);
        chk("ctrl bresp", 48'h0, 48'(r));
        if (cw[7]) begin
            cwm[u] = cw;
            for (int p = 0; p < 3; p++) lat[3*u+p] = 8'h00;
        end
    endtask : cw_wr
    task automatic pw(input int p, input logic [7:0] v);
        logic [1:0] r;
        axw(dpp_pkg::OFF_PORT0 + 8'(4*p), {24'h0, v}, r);
        chk("port bresp", 48'h0, 48'(r));
        lat[p] = v;
    endtask : pw
    task automatic pins();
        logic [31:0] d;
        logic [1:0]  r;
        repeat (8) @(posedge aclk);
        chk("oe", exp_oe(), loe);
        chk("out", exp_lvl() & exp_oe(), lout & loe);
        for (int p = 0; p < 6; p++) begin
            axr(dpp_pkg::OFF_PORT0 + 8'(4*p), d, r);
            chk("port", (exp_lvl() >> (8*p)) & 48'hFF, 48'(d[7:0]));
        end
    endtask : pins
    // ========================================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        cwm[0] = 8'h9B;
        cwm[1] = 8'h9B;
        for (int p = 0; p < 6; p++) lat[p] = 8'h00;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        #1;
        chk("oe after reset", 48'h0, loe);
        for (int u = 0; u < 2; u++) begin
            axr(dpp_pkg::OFF_CTRL0 + 8'(4*u), d, r);
            chk("ctrl reset", 48'h9B, 48'(d[7:0]));
        end
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            cw_wr(i / 16, 8'h80 | {3'h0, i[3], i[2], 1'h0, i[1], i[0]});
            for (int p = 0; p < 3; p++) pw(3*(i/16) + p, 8'(xs()));
            ext_val <= 48'({xs(), xs()});
            ext_en <= 48'({xs(), xs()});
            pins();
        end
        $display("test modes done");
        cw_wr(1, 8'h80);
        for (int p = 3; p < 6; p++) pw(p, 8'(xs()));
        cw_wr(1, 8'h1B);
        pins();
        axr(dpp_pkg::OFF_CTRL1, d, r);
        chk("ctrl kept", 48'h80, 48'(d[7:0]));
        $display("test ignore done");
        axr(dpp_pkg::OFF_ALLLO, d, r);
        chk("bulk low", exp_lvl() & 48'hFFFFFFFF, 48'(d));
        axr(dpp_pkg::OFF_ALLHI, d, r);
        chk("bulk high", exp_lvl() >> 32, 48'(d[15:0]));
        axw(8'h40, 32'hFFFFFFFF, r);
        chk("unmapped bresp", 48'h2, 48'(r));
        axr(8'h40, d, r);
        chk("unmapped rresp", 48'h2, 48'(r));
        pins();
        d = xs();
        axw(dpp_pkg::OFF_ALLLO, d, r);
        chk("bulk low bresp", 48'h0, 48'(r));
        for (int p = 0; p < 4; p++) lat[p] = d[8*p +: 8];
        d = xs();
        axw(dpp_pkg::OFF_ALLHI, d, r);
        chk("bulk high bresp", 48'h0, 48'(r));
        lat[4] = d[7:0];
        lat[5] = d[15:8];
        pins();
        $display("test bus done");
        stop_test();
    end
endmodule : tb
bind dpp_top dpp_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .io_line_out(io_line_out), .io_line_oe(io_line_oe));
`default_nettype wire
